/* File: hdl/sram_write_host.sv */
// Host controller issuing strobe-controlled writes to the battery SRAM
`timescale 1ns/1ps
`default_nettype none
module sram_write_host #(
    parameter int REC_CYCLES = sram_host_pkg::REC_CYC
) (
    input  wire logic                        clk,
    input  wire logic                        reset,
    input  wire logic                        supply_ok,
    input  wire logic                        req_valid,
    input  wire sram_host_pkg::wr_req_s      req,
    output logic                             req_ready,
    output logic                             busy,
    output logic                             link_ready,
    output sram_host_pkg::sram_ctl_s         ctl,
    output logic [sram_host_pkg::DATA_W-1:0] data_out,
    output logic [sram_host_pkg::DATA_W-1:0] data_oe
);
    import sram_host_pkg::*;

    wr_state_e          state_ff;
    logic [7:0]         cnt_ff;
    logic [ADDR_W-1:0]  addr_ff;
    logic [DATA_W-1:0]  data_ff;
    logic               sel_ff;
    logic               strobe_ff;
    logic               drive_ff;
    logic               ready_int;

    ////////////////////////////////////////////////////////////////////////////
    power_guard #(
        .REC_CYCLES (REC_CYCLES)
    ) u_guard (
        .clk        (clk),
        .reset      (reset),
        .supply_ok  (supply_ok),
        .link_ready (ready_int)
    );

    assign link_ready = ready_int;
    assign req_ready  = (state_ff == st_idle) && ready_int;
    assign busy       = (state_ff != st_idle);

    ////////////////////////////////////////////////////////////////////////////
    // Sequence: setup (select, addr, data, gate high) -> strobe low -> release
    // -> recovery gap. Strobe-controlled so the select edge never coincides
    // with strobe fall ambiguity on the device side.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_ff  <= st_idle;
            cnt_ff    <= 8'h00;
            addr_ff   <= '0;
            data_ff   <= '0;
            sel_ff    <= 1'b0;
            strobe_ff <= 1'b0;
            drive_ff  <= 1'b0;
        end else begin
            case (state_ff)
                st_idle: begin
                    if (req_valid && ready_int) begin
                        addr_ff  <= req.addr;
                        data_ff  <= req.data;
                        sel_ff   <= 1'b1;
                        drive_ff <= 1'b1;
                        cnt_ff   <= 8'(HIZ_CYC);
                        state_ff <= st_setup;
                    end
                end
                st_setup: begin
                    // Gate held high, device data lines float before we strobe
                    if (cnt_ff <= 8'h01) begin
                        strobe_ff <= 1'b1;
                        cnt_ff    <= 8'((WPULSE_CYC > DSETUP_CYC) ? WPULSE_CYC : DSETUP_CYC);
                        state_ff  <= st_strobe;
                    end else begin
                        cnt_ff <= cnt_ff - 8'h01;
                    end
                end
                st_strobe: begin
                    if (!ready_int) begin
                        // Supply lost: end write at once, device protects array
                        strobe_ff <= 1'b0;
                        cnt_ff    <= 8'(CYCLE_CYC);
                        state_ff  <= st_recover;
                    end else if (cnt_ff <= 8'h01) begin
                        strobe_ff <= 1'b0;
                        cnt_ff    <= 8'(DHOLD_CYC + AHOLD_CYC + CYCLE_CYC);
                        state_ff  <= st_recover;
                    end else begin
                        cnt_ff <= cnt_ff - 8'h01;
                    end
                end
                st_recover: begin
                    // Data held past strobe rise, then select dropped for the gap
                    if (cnt_ff == 8'(CYCLE_CYC)) begin
                        drive_ff <= 1'b0;
                        sel_ff   <= 1'b0;
                    end
                    if (cnt_ff <= 8'h01) begin
                        state_ff <= st_idle;
                    end else begin
                        cnt_ff <= cnt_ff - 8'h01;
                    end
                end
                default: begin
                    state_ff <= st_idle;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        ctl.select_active_low  = ~(sel_ff && ready_int);
        ctl.select_active_high = sel_ff && ready_int;
        ctl.write_strobe_n     = ~strobe_ff;
        ctl.output_gate_n      = 1'b1;
        ctl.addr               = addr_ff;
    end

    assign data_out = data_ff;
    assign data_oe  = {DATA_W{drive_ff}};
endmodule // sram_write_host
`default_nettype wire

/* File: hdl/sram_host_pkg.sv */
// Package: pin groups, timing and command types for the battery SRAM host controller
`default_nettype none
package sram_host_pkg;

    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;

    localparam int CLK_MHZ = 100;
    // Write cycle timing, ns
    localparam int T_CYCLE_NS     = 70;
    localparam int T_WPULSE_NS    = 50;
    localparam int T_DSETUP_NS    = 30;
    localparam int T_DHOLD_NS     = 5;
    localparam int T_AHOLD_NS     = 0;
    localparam int T_OUT_HIZ_NS   = 25;
    // Power-up recovery, ms: wait the longest figure before trusting the device
    localparam int T_REC_MAX_MS   = 200;

    localparam int CYC_NS = 1000 / CLK_MHZ;
    function automatic int ceil_cycles(input int ns);
        int c;
        c = (ns + CYC_NS - 1) / CYC_NS;
        return (c < 1) ? 1 : c;
    endfunction
    localparam int WPULSE_CYC = ceil_cycles(T_WPULSE_NS);
    localparam int DSETUP_CYC = ceil_cycles(T_DSETUP_NS);
    localparam int DHOLD_CYC  = ceil_cycles(T_DHOLD_NS);
    localparam int AHOLD_CYC  = ceil_cycles(T_AHOLD_NS);
    localparam int HIZ_CYC    = ceil_cycles(T_OUT_HIZ_NS);
    localparam int CYCLE_CYC  = ceil_cycles(T_CYCLE_NS);
    localparam int REC_CYC    = T_REC_MAX_MS * 1000 * CLK_MHZ;

    localparam int CNT_W = 25;

    typedef enum logic [1:0] {
        st_idle,
        st_setup,
        st_strobe,
        st_recover
    } wr_state_e;

    // Pins driven toward the device
    typedef struct packed {
        logic                select_active_low;
        logic                select_active_high;
        logic                write_strobe_n;
        logic                output_gate_n;
        logic [ADDR_W-1:0]   addr;
    } sram_ctl_s;

    // User write request
    typedef struct packed {
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   data;
    } wr_req_s;

endpackage
`default_nettype wire

/* File: hdl/power_guard.sv */
// Power guard: holds writes off while supply bad and for the recovery delay after
`timescale 1ns/1ps
`default_nettype none
module power_guard #(
    parameter int REC_CYCLES = sram_host_pkg::REC_CYC
) (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic supply_ok,
    output logic      link_ready
);
    import sram_host_pkg::*;

    logic             sync1_ff;
    logic             sync2_ff;
    logic [CNT_W-1:0] wait_ff;
    logic             ready_ff;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
        end else begin
            sync1_ff <= supply_ok;
            sync2_ff <= sync1_ff;
        end
    end

    // Waits the longest recovery so any device inside 40..200 ms is ready
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wait_ff  <= '0;
            ready_ff <= 1'b0;
        end else if (!sync2_ff) begin
            wait_ff  <= '0;
            ready_ff <= 1'b0;
        end else if (!ready_ff) begin
            if (wait_ff == CNT_W'(REC_CYCLES - 1)) begin
                ready_ff <= 1'b1;
            end else begin
                wait_ff <= wait_ff + 1'b1;
            end
        end
    end

    assign link_ready = ready_ff;
endmodule // power_guard
`default_nettype wire

/* File: testbench/sram_write_host_checker.sv */
// Checker: host-side pin rules of the SRAM write controller
`timescale 1ns/1ps
`default_nettype none
module sram_write_host_checker (
    input wire logic                     clk,
    input wire logic                     reset,
    input wire logic                     link_ready,
    input wire sram_host_pkg::sram_ctl_s ctl
);
    import sram_host_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic wr;
    assign wr = !ctl.select_active_low && ctl.select_active_high && !ctl.write_strobe_n;
    sequence strobe_end;
        $rose(ctl.write_strobe_n);
    endsequence
    sequence strobe_rest;
        ctl.write_strobe_n [*8];
    endsequence
    a_addr_stable: assert property (wr ##1 wr |-> $stable(ctl.addr))
        else $error("address moved inside a write");
    a_strobe_gap: assert property (strobe_end |-> strobe_rest)
        else $error("strobe low again too soon");
    a_gate_high: assert property (!ctl.select_active_low |-> ctl.output_gate_n)
        else $error("output gate low while selected");
    a_sel_link: assert property (!link_ready |-> ctl.select_active_low || !ctl.select_active_high)
        else $error("selected before supply recovery");
endmodule // sram_write_host_checker
bind sram_write_host sram_write_host_checker chk (.clk(clk), .reset(reset), .link_ready(link_ready), .ctl(ctl));
`default_nettype wire

/* File: testbench/sram_model.sv */
// Partner model: battery SRAM array with power-fail deselect
`timescale 1ns/1ps
`default_nettype none
module sram_model #(
    parameter int REC_NS = 100
) (
    input wire logic                             supply_ok,
    input wire sram_host_pkg::sram_ctl_s         ctl,
    input wire logic [sram_host_pkg::DATA_W-1:0] dq
);
    import sram_host_pkg::*;
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic              powered = 1'b0;
    logic              wr;
    // Level waits, so a supply already good at time zero is never missed
    // Deselect at once, well inside the allowed lag
    always begin
        wait (supply_ok === 1'b1);
        #(REC_NS);
        powered = (supply_ok === 1'b1);
        wait (supply_ok !== 1'b1);
        powered = 1'b0;
    end
    // Gate never low here, so data lines are never driven
    assign wr = powered && !ctl.select_active_low && ctl.select_active_high && !ctl.write_strobe_n;
    // Power loss ends a write unstored, other bytes untouched
    always @(negedge wr) begin
        if (powered)
            mem[ctl.addr] = dq;
    end
endmodule // sram_model
`default_nettype wire

/* File: testbench/tb_sram_write_host.sv */
// Testbench: table writes, power loss and mid-run reset against the SRAM model
`timescale 1ns/1ps
`default_nettype none
module tb_sram_write_host;
    import sram_host_pkg::*;
    logic              clk, reset, supply_ok, req_valid, req_ready, busy, link_ready;
    wr_req_s           req;
    sram_ctl_s         ctl;
    logic [DATA_W-1:0] data_out, data_oe;
    wire [DATA_W-1:0]  dq;
    int                err_count = 0, samples_checked = 0, cyc = 0, i;
    wr_req_s           rows [4] = '{'{13'h0000, 8'h5a}, '{13'h1fff, 8'ha5}, '{13'h0001, 8'hff}, '{13'h1ffe, 8'h00}};
    assign dq = (data_oe == 8'hff) ? data_out : 8'hzz;
    sram_write_host #(.REC_CYCLES(16)) dut (.clk(clk), .reset(reset), .supply_ok(supply_ok), .req_valid(req_valid),
        .req(req), .req_ready(req_ready), .busy(busy), .link_ready(link_ready), .ctl(ctl), .data_out(data_out),
        .data_oe(data_oe));
    sram_model model (.supply_ok(supply_ok), .ctl(ctl), .dq(dq));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_count++;
            test_done();
        end
    end
    ////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        if (n == 100)
            err_count++;
    endtask
    task automatic write(input wr_req_s r);
        wait_ready();
        req = r;
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
    endtask
    task automatic test_done();
        $display("checked %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        reset = 1'b1;
        supply_ok = 1'b1;
        req_valid = 1'b0;
        req = '0;
        repeat (5) @(negedge clk);
        check({ctl.select_active_low, ctl.select_active_high, ctl.output_gate_n}, 3'b101);
        reset = 1'b0;
        check(req_ready, 1'b0);
        // Back to back, address extremes
        for (i = 0; i < 4; i++) begin
            write(rows[i]);
            check(busy, 1'b1);
            check({data_oe, data_out}, {8'hff, rows[i].data});
        end
        wait_ready();
        check({busy, data_oe}, 9'h000);
        for (i = 0; i < 4; i++)
            check(model.mem[rows[i].addr], rows[i].data);
        $display("table writes done");
        // Supply lost while the strobe is low
        write('{13'h0002, 8'h3c});
        repeat (4) @(negedge clk);
        supply_ok = 1'b0;
        repeat (4) @(negedge clk);
        check({link_ready, ctl.select_active_low}, 2'b01);
        check(model.mem[13'h0001], 8'hff);
        supply_ok = 1'b1;
        repeat (6) @(negedge clk);
        check({req_ready, ctl.select_active_low}, 2'b01);
        write('{13'h0002, 8'hc3});
        wait_ready();
        check(model.mem[13'h0002], 8'hc3);
        $display("power loss test done");
        // Reset pulled while the strobe is low, then a clean write once the link recovers
        write('{13'h0003, 8'h69});
        repeat (4) @(negedge clk);
        reset = 1'b1;
        @(negedge clk);
        check({ctl.select_active_low, ctl.select_active_high, ctl.write_strobe_n, busy, req_ready, link_ready}, 6'h28);
        check(data_oe, 8'h00);
        reset = 1'b0;
        check(req_ready, 1'b0);
        write('{13'h0003, 8'h96});
        wait_ready();
        check(model.mem[13'h0003], 8'h96);
        $display("mid-run reset test done");
        test_done();
    end
endmodule // tb_sram_write_host
`default_nettype wire
